//--- rtl/eeprom_host_pkg.sv
// constants and carrier types for the parallel eeprom host controller
package eeprom_host_pkg;
   localparam int CLK_MHZ    = 100;
   localparam int ADDR_W     = 11;
   localparam int DATA_W     = 8;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_LSB   = 4;
   localparam int CNT_W      = 16;
   localparam int SYNC_CYC   = 2;
   // pin timing, in the unit that ends each name
   localparam int T_AS_NS    = 5;
   localparam int T_WP_NS    = 100;
   localparam int T_WPH_NS   = 50;
   localparam int T_ACC_NS   = 200;
   localparam int T_HZ_NS    = 60;
   localparam int T_BLC_US   = 20;
   localparam int T_DW_US    = 10;
   localparam int T_WC_MS    = 10;

   function automatic int min_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : min_cyc

   localparam int AS_CYC      = min_cyc(T_AS_NS);
   localparam int WP_CYC      = min_cyc(T_WP_NS);
   localparam int WPH_CYC     = min_cyc(T_WPH_NS);
   localparam int ACC_CYC     = min_cyc(T_ACC_NS) + SYNC_CYC;
   localparam int HZ_CYC      = min_cyc(T_HZ_NS);
   localparam int DW_CYC      = min_cyc(T_DW_US * 1000);
   localparam int BLC_MAX_CYC = T_BLC_US * CLK_MHZ;
   localparam int WC_CYC_DEF  = T_WC_MS * 1000 * CLK_MHZ;

   typedef enum logic {OP_READ = 1'h0, OP_WRITE = 1'h1} op_t;

   typedef struct packed {
      op_t               op;
      logic [ADDR_W-1:0] addr;
      logic [4:0]        count;
   } req_t;

   typedef struct packed {
      logic              chip_sel_n;
      logic              out_gate_n;
      logic              wr_strobe_n;
      logic [ADDR_W-1:0] addr_lines;
      logic [DATA_W-1:0] data_out;
      logic              data_oe;
   } pins_t;

   localparam pins_t PINS_IDLE = '{chip_sel_n: 1'h1, out_gate_n: 1'h1,
      wr_strobe_n: 1'h1, addr_lines: 11'h000, data_out: 8'h00,
      data_oe: 1'h0};
endpackage : eeprom_host_pkg

//--- rtl/page_buffer.sv
// page image buffer: one write port, registered read port
`timescale 1ns/1ps
module page_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int IDX_W = $clog2(DEPTH)
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [IDX_W-1:0] rd_idx,
   output      logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_idx];
      end
   end
endmodule : page_buffer

//--- rtl/eeprom_page_host.sv
// host controller driving a byte-wide eeprom: reads, page writes, polling
// Operation
// - read only with gate and select low, strobe high
// - write only with select and strobe low, gate high
// - upper address bits four to ten stay fixed within a page
// - after the first byte, one to fifteen more loads may follow
// - each further strobe fall comes within 20 us of the last
// - gate low, strobe high or select high blocks writes
// - select decoded from address; gate and strobe shared
// - a completion poll is an ordinary timed read cycle
// - gate may pulse low between page loads
// - without polling, wait the full write cycle time
`timescale 1ns/1ps
module eeprom_page_host
   import eeprom_host_pkg::*;
#(
   parameter int WC_CYC = WC_CYC_DEF
) (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic              req_valid,
   input  wire req_t              req,
   output      logic              req_ready,
   input  wire logic              poll_en,
   input  wire logic              buf_we,
   input  wire logic [3:0]        buf_idx,
   input  wire logic [DATA_W-1:0] buf_wdata,
   output      logic              rsp_valid,
   output      logic [DATA_W-1:0] rsp_data,
   output      logic              rsp_timeout,
   output      pins_t             pins,
   input  wire logic [DATA_W-1:0] data_in
);
   localparam int WC_W = $clog2(WC_CYC + 1);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_WSET  = 3'h1,
      ST_WLOW  = 3'h3,
      ST_WHIGH = 3'h2,
      ST_PROG  = 3'h6,
      ST_RACC  = 3'h7,
      ST_RREL  = 3'h5,
      ST_GAP   = 3'h4
   } state_t;

   state_t            state_reg;
   logic [CNT_W-1:0]  cnt_reg;
   logic [WC_W-1:0]   wc_reg;
   logic [3:0]        idx_reg;
   logic [4:0]        count_reg;
   logic [ADDR_W-1:0] base_reg;
   logic [DATA_W-1:0] last_reg;
   logic              poll_reg;
   logic [DATA_W-1:0] sync1_reg;
   logic [DATA_W-1:0] sync2_reg;
   logic [DATA_W-1:0] buf_rdata;
   logic [3:0]        rd_idx;
   logic              take;
   logic              last_byte;
   logic              wc_done;

   assign take      = req_valid && req_ready;
   assign rd_idx    = 4'(base_reg[PAGE_LSB-1:0] + idx_reg);
   assign last_byte = (5'(idx_reg) + 5'h01 == count_reg);
   assign wc_done   = (wc_reg >= WC_W'(WC_CYC - 1));

   // buffer may only change while idle, so a page in flight stays intact
   page_buffer #(.WIDTH(DATA_W), .DEPTH(PAGE_BYTES)) u_page (
      .clock   (clock),
      .sys_rst (sys_rst),
      .wr_en   (buf_we && req_ready),
      .wr_idx  (buf_idx),
      .wr_data (buf_wdata),
      .rd_idx  (rd_idx),
      .rd_data (buf_rdata)
   );

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= data_in;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= '0;
         wc_reg      <= '0;
         idx_reg     <= '0;
         count_reg   <= 5'h01;
         base_reg    <= '0;
         last_reg    <= '0;
         poll_reg    <= 1'b0;
         pins        <= PINS_IDLE;
         req_ready   <= 1'b0;
         rsp_valid   <= 1'b0;
         rsp_data    <= '0;
         rsp_timeout <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (poll_reg && !wc_done) begin
            wc_reg <= wc_reg + WC_W'(1);
         end
         unique case (state_reg)
            ST_IDLE: begin
               req_ready <= 1'b1;
               if (take) begin
                  req_ready        <= 1'b0;
                  base_reg         <= req.addr;
                  idx_reg          <= '0;
                  pins.addr_lines  <= req.addr;
                  pins.chip_sel_n  <= 1'b0;
                  if (req.op == OP_WRITE) begin
                     // a count of one is a byte write, more extend it
                     if (req.count == 5'h00) begin
                        count_reg <= 5'h01;
                     end else if (req.count > 5'(PAGE_BYTES)) begin
                        count_reg <= 5'(PAGE_BYTES);
                     end else begin
                        count_reg <= req.count;
                     end
                     cnt_reg   <= CNT_W'(AS_CYC);
                     state_reg <= ST_WSET;
                  end else begin
                     pins.out_gate_n <= 1'b0;
                     cnt_reg         <= CNT_W'(ACC_CYC - 1);
                     state_reg       <= ST_RACC;
                  end
               end
            end
            ST_WSET: begin
               // address settles before the strobe falls; the extra cycle
               // lets the registered buffer read catch up with the index
               cnt_reg <= cnt_reg - CNT_W'(1);
               if (cnt_reg == '0) begin
                  pins.wr_strobe_n <= 1'b0;
                  pins.data_out    <= buf_rdata;
                  pins.data_oe     <= 1'b1;
                  last_reg         <= buf_rdata;
                  cnt_reg          <= CNT_W'(WP_CYC - 1);
                  state_reg        <= ST_WLOW;
               end
            end
            ST_WLOW: begin
               cnt_reg <= cnt_reg - CNT_W'(1);
               if (cnt_reg == '0) begin
                  pins.wr_strobe_n <= 1'b1;
                  cnt_reg          <= CNT_W'(WPH_CYC - 1);
                  state_reg        <= ST_WHIGH;
               end
            end
            ST_WHIGH: begin
               cnt_reg <= cnt_reg - CNT_W'(1);
               if (cnt_reg == '0) begin
                  pins.data_oe <= 1'b0;
                  if (last_byte) begin
                     // leave the device deselected so it starts programming
                     pins.chip_sel_n <= 1'b1;
                     wc_reg          <= '0;
                     poll_reg        <= poll_en;
                     state_reg       <= ST_PROG;
                  end else begin
                     idx_reg <= idx_reg + 4'h1;
                     // only the low bits move: the page stays put
                     pins.addr_lines[PAGE_LSB-1:0] <=
                        4'(base_reg[PAGE_LSB-1:0] + idx_reg + 4'h1);
                     cnt_reg   <= CNT_W'(AS_CYC);
                     state_reg <= ST_WSET;
                  end
               end
            end
            ST_PROG: begin
               pins.addr_lines[PAGE_LSB-1:0] <=
                  4'(base_reg[PAGE_LSB-1:0] + idx_reg);
               if (poll_reg) begin
                  pins.chip_sel_n <= 1'b0;
                  pins.out_gate_n <= 1'b0;
                  cnt_reg         <= CNT_W'(ACC_CYC - 1);
                  state_reg       <= ST_RACC;
               end else begin
                  // blind wait: the full worst case write time
                  wc_reg <= wc_reg + WC_W'(1);
                  if (wc_done) begin
                     rsp_timeout <= 1'b0;
                     cnt_reg     <= CNT_W'(DW_CYC - 1);
                     state_reg   <= ST_GAP;
                  end
               end
            end
            ST_RACC: begin
               cnt_reg <= cnt_reg - CNT_W'(1);
               if (cnt_reg == '0) begin
                  rsp_data        <= sync2_reg;
                  pins.out_gate_n <= 1'b1;
                  pins.chip_sel_n <= 1'b1;
                  cnt_reg         <= CNT_W'(HZ_CYC - 1);
                  state_reg       <= ST_RREL;
               end
            end
            ST_RREL: begin
               // the device needs this long to float its outputs
               cnt_reg <= cnt_reg - CNT_W'(1);
               if (cnt_reg == '0) begin
                  if (!poll_reg) begin
                     rsp_timeout <= 1'b0;
                     rsp_valid   <= 1'b1;
                     state_reg   <= ST_IDLE;
                  end else if (rsp_data[7] == last_reg[7] || wc_done) begin
                     rsp_timeout <= (rsp_data[7] != last_reg[7]);
                     poll_reg    <= 1'b0;
                     cnt_reg     <= CNT_W'(DW_CYC - 1);
                     state_reg   <= ST_GAP;
                  end else begin
                     pins.chip_sel_n <= 1'b0;
                     pins.out_gate_n <= 1'b0;
                     cnt_reg         <= CNT_W'(ACC_CYC - 1);
                     state_reg       <= ST_RACC;
                  end
               end
            end
            ST_GAP: begin
               cnt_reg <= cnt_reg - CNT_W'(1);
               if (cnt_reg == '0) begin
                  rsp_valid <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // helper counters seen only by the checks below
   logic [CNT_W-1:0] blc_cnt;
   logic [4:0]       fall_cnt;
   always_ff @(posedge clock) begin
      if (sys_rst || state_reg == ST_IDLE) begin
         blc_cnt  <= '0;
         fall_cnt <= '0;
      end else if ($fell(pins.wr_strobe_n)) begin
         blc_cnt  <= '0;
         fall_cnt <= fall_cnt + 5'h01;
      end else if (blc_cnt != '1) begin
         blc_cnt <= blc_cnt + CNT_W'(1);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence s_strobe_low_ten;
      (!pins.wr_strobe_n)[*8] ##1 !pins.wr_strobe_n ##1 !pins.wr_strobe_n;
   endsequence
   sequence s_strobe_release;
      pins.wr_strobe_n && pins.data_oe;
   endsequence

   a_read_form: assert property (
      !pins.out_gate_n && !pins.chip_sel_n |-> pins.wr_strobe_n)
      else $error("read strobes with write strobe low");
   a_write_form: assert property (
      !pins.wr_strobe_n |-> !pins.chip_sel_n && pins.out_gate_n)
      else $error("write strobe low without select or with gate low");
   a_no_contend: assert property (
      pins.data_oe |-> pins.out_gate_n && $past(pins.out_gate_n))
      else $error("host drives data while device may drive");
   a_strobe_width: assert property (
      $fell(pins.wr_strobe_n) |-> s_strobe_low_ten ##1 s_strobe_release)
      else $error("write strobe pulse not ten cycles");
   a_addr_at_fall: assert property (
      $fell(pins.wr_strobe_n) |-> $stable(pins.addr_lines)
         && pins.addr_lines == $past(pins.addr_lines, 2))
      else $error("address moved at strobe fall");
   a_data_at_rise: assert property (
      $rose(pins.wr_strobe_n) |-> pins.data_oe && $stable(pins.data_out)
         && pins.data_out == last_reg)
      else $error("data not held at strobe rise");
   a_page_fixed: assert property (
      $fell(pins.wr_strobe_n) |->
         pins.addr_lines[ADDR_W-1:PAGE_LSB] == base_reg[ADDR_W-1:PAGE_LSB])
      else $error("page address changed within a page");
   a_load_gap: assert property (
      $fell(pins.wr_strobe_n) && fall_cnt != 5'h00
         |-> blc_cnt < CNT_W'(BLC_MAX_CYC))
      else $error("byte load gap too long");
   a_page_len: assert property (
      fall_cnt <= 5'(PAGE_BYTES) && fall_cnt <= count_reg)
      else $error("too many byte loads in one page");
   a_quiet_prog: assert property (
      state_reg == ST_PROG || state_reg == ST_RREL |-> pins.wr_strobe_n
         ##1 pins.wr_strobe_n)
      else $error("write strobe during programming");
endmodule : eeprom_page_host

//--- dv/eeprom_model.sv
// behavioural model of the byte-wide eeprom behind the host pins
`timescale 1ns/1ps
module eeprom_model
   import eeprom_host_pkg::*;
(
   input  wire logic              clock,
   input  wire pins_t             pins,
   input  wire logic [15:0]       prog_cyc,
   output      logic [DATA_W-1:0] data_in,
   output      logic              busy,
   output      logic              viol
);
   localparam int BLC_CYC = T_BLC_US * CLK_MHZ;
   localparam int ACC_M   = 18;
   logic [7:0]  mem [2048];
   logic [7:0]  pend [16];
   logic [15:0] pend_v = '0;
   logic [10:0] lat_a = '0, last_a = '0;
   logic [7:0]  last_d = '0, prev_d = '0, rd_val;
   logic        wr_prev = 1'b0, loading = 1'b0, rd_sel, wr_sel;
   int          blc = 0, prog = 0, acc = 0;

   initial for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ {i[10:8], 5'h15};

   assign rd_sel = !pins.chip_sel_n && !pins.out_gate_n && pins.wr_strobe_n;
   assign wr_sel = !pins.chip_sel_n && !pins.wr_strobe_n && pins.out_gate_n;
   assign busy = loading || prog != 0;

   always_comb begin
      rd_val = mem[pins.addr_lines];
      if (busy && pins.addr_lines == last_a) begin
         rd_val = {~last_d[7], last_d[6:0]};
      end
      if (pins.data_oe) data_in = pins.data_out;
      else if (rd_sel && acc >= ACC_M) data_in = rd_val;
      else data_in = ~prev_d;
   end

   always @(posedge clock) begin
      viol <= pins.data_oe && rd_sel;
      prev_d <= data_in;
      wr_prev <= wr_sel;
      acc <= rd_sel ? acc + 1 : 0;
      if (prog == 0) begin
         // strobes shorter than one sample period can be missed
         if (wr_sel && !wr_prev) begin
            if (loading && lat_a[10:4] != pins.addr_lines[10:4]) begin
               viol <= 1'b1;
            end
            lat_a <= pins.addr_lines;
            loading <= 1'b1;
            blc <= 0;
         end else if (loading && blc == BLC_CYC - 1) begin
            loading <= 1'b0;
            prog <= prog_cyc;
         end else if (loading) begin
            blc <= blc + 1;
         end
         if (wr_prev && !wr_sel) begin
            pend[lat_a[3:0]] <= pins.data_out;
            pend_v[lat_a[3:0]] <= 1'b1;
            last_a <= lat_a;
            last_d <= pins.data_out;
         end
      end else begin
         prog <= prog - 1;
         if (prog == 1) begin
            for (int i = 0; i < 16; i++)
               if (pend_v[i]) mem[{last_a[10:4], 4'(i)}] <= pend[i];
            pend_v <= '0;
         end
      end
   end
endmodule : eeprom_model

//--- dv/eeprom_page_host_tb.sv
// self-checking bench: page host against the eeprom model
`timescale 1ns/1ps
module eeprom_page_host_tb
   import eeprom_host_pkg::*;
;
   localparam int WC = 4000;
   logic        clock = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
   logic        poll_en = 1'b0, buf_we = 1'b0;
   req_t        req = '0;
   logic [3:0]  buf_idx = 4'h0;
   logic [7:0]  buf_wdata = 8'h00, rsp_data, data_in;
   logic [15:0] prog_cyc = 16'h0100;
   logic        req_ready, rsp_valid, rsp_timeout, busy, viol;
   pins_t       pins;
   logic [31:0] seed = 32'h7116e4be;
   logic [7:0]  shadow [2048];
   logic [7:0]  pbuf [16];
   int          failures = 0, checks_done = 0;

   always #5 clock = ~clock;

   eeprom_page_host #(.WC_CYC(WC)) i_eeprom_page_host (.clock(clock),
      .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .poll_en(poll_en), .buf_we(buf_we),
      .buf_idx(buf_idx), .buf_wdata(buf_wdata), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .pins(pins),
      .data_in(data_in));
   eeprom_model i_eeprom_model (.clock(clock), .pins(pins),
      .prog_cyc(prog_cyc), .data_in(data_in), .busy(busy), .viol(viol));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // contention or a page change inside one load phase
   always @(posedge clock)
      if (viol !== 1'b0 && !sys_rst) check("pins", 0, 1);

   task automatic fill_buf();
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         pbuf[i] = 8'(rnd());
         buf_we <= 1'b1;
         buf_idx <= 4'(i);
         buf_wdata <= pbuf[i];
      end
      @(posedge clock);
      buf_we <= 1'b0;
   endtask : fill_buf

   task automatic run_req(input op_t op, input logic [10:0] a,
                          input logic [4:0] cnt);
      int n;
      n = 0;
      @(posedge clock);
      req_valid <= 1'b1;
      req <= '{op: op, addr: a, count: cnt};
      do begin @(negedge clock); n++; end while (req_ready !== 1'b1 && n < 9000);
      if (req_ready !== 1'b1) begin
         check("req_ready", 1, 0);
         report_and_stop();
      end
      @(posedge clock);
      req_valid <= 1'b0;
      // a slot write while busy must not reach the buffer
      @(posedge clock);
      buf_we <= 1'b1;
      buf_idx <= 4'(rnd());
      buf_wdata <= 8'(rnd());
      @(posedge clock);
      buf_we <= 1'b0;
      do begin @(negedge clock); n++; end while (rsp_valid !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         check("rsp_valid", 1, 0);
         report_and_stop();
      end
   endtask : run_req

   task automatic do_write(input logic [10:0] a, input logic [4:0] cnt,
                           input logic poll, input logic [15:0] pc);
      int n;
      logic [3:0] idx;
      @(posedge clock);
      poll_en <= poll;
      prog_cyc <= pc;
      run_req(OP_WRITE, a, cnt);
      n = cnt == 0 ? 1 : (cnt > 16 ? 16 : int'(cnt));
      for (int i = 0; i < n; i++) begin
         idx = a[3:0] + 4'(i);
         shadow[{a[10:4], idx}] = pbuf[idx];
      end
      check("rsp_timeout", {7'h0, poll && pc > 2000},
            {7'h0, rsp_timeout});
      if (poll && pc <= 2000) check("poll_data", pbuf[idx], rsp_data);
      n = 0;
      while (busy !== 1'b0 && n < 9000) begin @(posedge clock); n++; end
      if (busy !== 1'b0) begin
         check("busy", 0, 1);
         report_and_stop();
      end
      for (int i = 0; i < 16 + 1; i++) begin
         idx = a[3:0] + 4'(i);
         run_req(OP_READ, i < 16 ? {a[10:4], idx} : 11'(rnd()), 5'h01);
         check("read_data", shadow[req.addr], rsp_data);
      end
   endtask : do_write

   initial begin
      logic [4:0] cnt;
      logic [4:0] corner [4];
      corner = '{5'h01, 5'h10, 5'h00, 5'h11};
      for (int i = 0; i < 2048; i++) shadow[i] = 8'(i) ^ {i[10:8], 5'h15};
      repeat (19) @(posedge clock);
      @(negedge clock);
      check("idle_pins", 8'h07, {5'h0, pins.chip_sel_n,
            pins.out_gate_n, pins.wr_strobe_n});
      check("ready_in_reset", 8'h00, {7'h0, req_ready});
      @(posedge clock);
      sys_rst <= 1'b0;
      fill_buf();
      for (int k = 0; k < 10; k++) begin
         cnt = k < 4 ? corner[k] : 5'(rnd() % 16 + 1);
         if (k > 0 && rnd() % 2 == 1) fill_buf();
         do_write(11'(rnd()), cnt, k == 5 ? 1'b1 : rnd() % 2 == 1,
            k == 5 ? 16'd6000 : 16'(50 + rnd() % 1450));
      end
      report_and_stop();
   end
endmodule : eeprom_page_host_tb
